// >>> rtl/irq_ctrl.sv
// Purpose: Two-level priority interrupt controller with AXI4-Lite register access.
// Assumes: One instruction cycle of the core is one aclk cycle; peripheral requests arrive already
//          gated by their own flags and enables and split by priority.
// Notes:   The core acks with irq_ack and ends a routine with return_from_interrupt_instr.
//
// What this block does
// - Vector 000008h for high, 000018h for low.
// - High request preempts running low routine.
// - Flag, enable, priority per source; pin zero high.
// - Priority mode bit 7 of reset status, default off.
// - Priority mode: bit 7 gates high sources.
// - Priority mode: bit 6 gates low sources.
// - Flag, enable and global enable vector immediately.
// - Compatibility mode: priorities ignored, vector 000008h.
// - Compat: bit 6 peripherals, bit 7 all.
// - Acceptance clears the global enable that applied.
// - Low requests held off during high routine.
// - Return instruction sets the matching global enable.
// - Pin latency three to four cycles, port-change two.
// - Flags set regardless of any enable.
// - Main control bits five to zero layout.
// - Edge-select bits 6..4 choose pin edges.
// - Bit 7 disables pull-ups, else latch enables.
// - Bit 2 timer priority, bit 0 port-change.
// - Pin one/two priorities, enables, flags.
//
// The implementer's own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/10ps
`include "irq_ctrl_defines.svh"

module irq_ctrl (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Event sources and port latch
  input  wire logic        timer_zero_overflow_evt,
  input  wire logic [2:0]  ext_pin,
  input  wire logic [3:0]  upper_port_pins,
  input  wire logic        port_b_register_read,
  input  wire logic        periph_req_high,
  input  wire logic        periph_req_low,
  input  wire logic [7:0]  port_latch,
  // Core side and port pull-ups
  input  wire logic        irq_ack,
  input  wire logic        return_from_interrupt_instr,
  output logic             irq_req,
  output logic [23:0]      irq_vector,
  output logic             port_pullup_disable,
  output logic [7:0]       pullup_enable
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [7:0]  main_ctrl;
    logic [7:0]  edge_pri;
    logic [7:0]  ext_ctrl;
    logic        prio_mode;
    logic        high_active;
    logic        low_active;
    logic        irq_req;
    logic [23:0] vector;
    logic        pu_dis;
    logic [7:0]  pu_en;
    logic        aw_got;
    logic [7:0]  waddr;
    logic        w_got;
    logic [7:0]  wdata;
    logic        wlane0;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } state_t;

  state_t      state_ff;
  state_t      nxt_state;
  logic [2:0]  pin_edge;
  logic        port_mismatch;
  logic        t0_req;
  logic        p0_req;
  logic        pc_req;
  logic        p1_req;
  logic        p2_req;
  logic        any_high;
  logic        any_low;
  logic        high_req;
  logic        low_req;
  logic        compat_req;

  // Shared by the read and write paths.
  function automatic irq_ctrl_pkg::reg_id_t reg_decode(input logic [7:0] addr);
    irq_ctrl_pkg::reg_id_t id;
    case (addr)
      `OFS_MAIN_CTRL:     id = irq_ctrl_pkg::REG_MAIN;
      `OFS_EDGE_PRI_CTRL: id = irq_ctrl_pkg::REG_EDGE_PRI;
      `OFS_EXT_PIN_CTRL:  id = irq_ctrl_pkg::REG_EXT_PIN;
      `OFS_RESET_STATUS:  id = irq_ctrl_pkg::REG_RESET_STATUS;
      `OFS_CTRL_STATUS:   id = irq_ctrl_pkg::REG_CTRL_STATUS;
      default:            id = irq_ctrl_pkg::REG_NONE;
    endcase
    return id;
  endfunction : reg_decode

  // ****************************************************************
  // Event front ends
  // ****************************************************************
  pin_edge_detect u_pin_edge (
    .aclk            (aclk),
    .aresetn         (aresetn),
    .pin_in          (ext_pin),
    .edge_rising_sel ({state_ff.edge_pri[`EDGE_SEL_P2_BIT],
                       state_ff.edge_pri[`EDGE_SEL_P1_BIT],
                       state_ff.edge_pri[`EDGE_SEL_P0_BIT]}),
    .edge_pulse      (pin_edge)
  );

  port_change_detect u_port_change (
    .aclk                 (aclk),
    .aresetn              (aresetn),
    .upper_port_pins      (upper_port_pins),
    .port_b_register_read (port_b_register_read),
    .mismatch             (port_mismatch)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    nxt_state = state_ff;

    // Address and data may come in either order.
    if (s_axi_awvalid && state_ff.awready)
    begin
      nxt_state.aw_got = 1'b1;
      nxt_state.waddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && state_ff.wready)
    begin
      nxt_state.w_got  = 1'b1;
      nxt_state.wdata  = s_axi_wdata[7:0];
      nxt_state.wlane0 = s_axi_wstrb[0];
    end
    if (state_ff.bvalid && s_axi_bready)
      nxt_state.bvalid = 1'b0;

    // Register write; only byte lane 0 carries data.
    if (state_ff.aw_got && state_ff.w_got && !state_ff.bvalid)
    begin
      nxt_state.aw_got = 1'b0;
      nxt_state.w_got  = 1'b0;
      nxt_state.bvalid = 1'b1;
      nxt_state.bresp  = `RESP_OKAY;
      case (reg_decode(state_ff.waddr))
        irq_ctrl_pkg::REG_MAIN:
        begin
          if (state_ff.wlane0)
            nxt_state.main_ctrl = state_ff.wdata;
        end
        irq_ctrl_pkg::REG_EDGE_PRI:
        begin
          if (state_ff.wlane0)
            nxt_state.edge_pri = state_ff.wdata & `MASK_EDGE_PRI_CTRL;
        end
        irq_ctrl_pkg::REG_EXT_PIN:
        begin
          if (state_ff.wlane0)
            nxt_state.ext_ctrl = state_ff.wdata & `MASK_EXT_PIN_CTRL;
        end
        irq_ctrl_pkg::REG_RESET_STATUS:
        begin
          if (state_ff.wlane0)
            nxt_state.prio_mode = state_ff.wdata[`RST_PRIO_MODE_BIT];
        end
        irq_ctrl_pkg::REG_CTRL_STATUS:
        begin
          nxt_state.bresp = `RESP_OKAY;
        end
        default:
        begin
          nxt_state.bresp = `RESP_SLVERR;
        end
      endcase
    end
    nxt_state.awready = !nxt_state.aw_got && !nxt_state.bvalid;
    nxt_state.wready  = !nxt_state.w_got && !nxt_state.bvalid;

    // One read at a time, data registered.
    if (state_ff.rvalid && s_axi_rready)
      nxt_state.rvalid = 1'b0;
    if (s_axi_arvalid && state_ff.arready)
    begin
      nxt_state.rvalid = 1'b1;
      nxt_state.rresp  = `RESP_OKAY;
      nxt_state.rdata  = 32'h0000_0000;
      case (reg_decode(s_axi_araddr))
        irq_ctrl_pkg::REG_MAIN:         nxt_state.rdata[7:0] = state_ff.main_ctrl;
        irq_ctrl_pkg::REG_EDGE_PRI:     nxt_state.rdata[7:0] = state_ff.edge_pri;
        irq_ctrl_pkg::REG_EXT_PIN:      nxt_state.rdata[7:0] = state_ff.ext_ctrl;
        irq_ctrl_pkg::REG_RESET_STATUS: nxt_state.rdata[`RST_PRIO_MODE_BIT] = state_ff.prio_mode;
        irq_ctrl_pkg::REG_CTRL_STATUS:
        begin
          nxt_state.rdata = {state_ff.vector, 5'h00, state_ff.irq_req,
                             state_ff.low_active, state_ff.high_active};
        end
        default:                        nxt_state.rresp = `RESP_SLVERR;
      endcase
    end
    nxt_state.arready = !nxt_state.rvalid;

    // Applied after the write, so a set beats a same-cycle clear.
    if (timer_zero_overflow_evt)
      nxt_state.main_ctrl[`MAIN_T0_FLAG_BIT] = 1'b1;
    if (pin_edge[0])
      nxt_state.main_ctrl[`MAIN_P0_FLAG_BIT] = 1'b1;
    if (port_mismatch)
      nxt_state.main_ctrl[`MAIN_PC_FLAG_BIT] = 1'b1;
    if (pin_edge[1])
      nxt_state.ext_ctrl[`EXT_P1_FLAG_BIT] = 1'b1;
    if (pin_edge[2])
      nxt_state.ext_ctrl[`EXT_P2_FLAG_BIT] = 1'b1;

    // The core stacks the return address itself.
    if (irq_ack && state_ff.irq_req)
    begin
      if (!state_ff.prio_mode)
      begin
        nxt_state.main_ctrl[`MAIN_GLOBAL_BIT] = 1'b0;
        nxt_state.high_active = 1'b1;
      end
      else if (state_ff.vector == `VECTOR_HIGH)
      begin
        nxt_state.main_ctrl[`MAIN_GLOBAL_BIT] = 1'b0;
        nxt_state.high_active = 1'b1;
      end
      else
      begin
        nxt_state.main_ctrl[`MAIN_GROUP_BIT] = 1'b0;
        nxt_state.low_active = 1'b1;
      end
    end

    // Return re-enables the finishing level.
    if (return_from_interrupt_instr)
    begin
      if (!state_ff.prio_mode || state_ff.high_active)
      begin
        nxt_state.main_ctrl[`MAIN_GLOBAL_BIT] = 1'b1;
        nxt_state.high_active = 1'b0;
      end
      else
      begin
        nxt_state.main_ctrl[`MAIN_GROUP_BIT] = 1'b1;
        nxt_state.low_active = 1'b0;
      end
    end

    // Evaluated on the new state, so an accepted request drops at once.
    t0_req = nxt_state.main_ctrl[`MAIN_T0_FLAG_BIT] & nxt_state.main_ctrl[`MAIN_T0_EN_BIT];
    p0_req = nxt_state.main_ctrl[`MAIN_P0_FLAG_BIT] & nxt_state.main_ctrl[`MAIN_P0_EN_BIT];
    pc_req = nxt_state.main_ctrl[`MAIN_PC_FLAG_BIT] & nxt_state.main_ctrl[`MAIN_PC_EN_BIT];
    p1_req = nxt_state.ext_ctrl[`EXT_P1_FLAG_BIT] & nxt_state.ext_ctrl[`EXT_P1_EN_BIT];
    p2_req = nxt_state.ext_ctrl[`EXT_P2_FLAG_BIT] & nxt_state.ext_ctrl[`EXT_P2_EN_BIT];

    // Pin zero is always high.
    any_high = p0_req | periph_req_high |
               (t0_req & nxt_state.edge_pri[`EDGE_T0_PRI_BIT]) |
               (pc_req & nxt_state.edge_pri[`EDGE_PC_PRI_BIT]) |
               (p1_req & nxt_state.ext_ctrl[`EXT_P1_PRI_BIT]) |
               (p2_req & nxt_state.ext_ctrl[`EXT_P2_PRI_BIT]);
    any_low  = periph_req_low |
               (t0_req & ~nxt_state.edge_pri[`EDGE_T0_PRI_BIT]) |
               (pc_req & ~nxt_state.edge_pri[`EDGE_PC_PRI_BIT]) |
               (p1_req & ~nxt_state.ext_ctrl[`EXT_P1_PRI_BIT]) |
               (p2_req & ~nxt_state.ext_ctrl[`EXT_P2_PRI_BIT]);

    // High preempts a low routine; low waits out a high one.
    high_req = nxt_state.main_ctrl[`MAIN_GLOBAL_BIT] & any_high & ~nxt_state.high_active;
    low_req  = nxt_state.main_ctrl[`MAIN_GROUP_BIT] & any_low &
               ~nxt_state.high_active & ~nxt_state.low_active;

    compat_req = nxt_state.main_ctrl[`MAIN_GLOBAL_BIT] &
                 (t0_req | p0_req | pc_req | p1_req | p2_req |
                  (nxt_state.main_ctrl[`MAIN_GROUP_BIT] & (periph_req_high | periph_req_low)));

    if (!nxt_state.prio_mode)
    begin
      nxt_state.irq_req = compat_req;
      nxt_state.vector  = `VECTOR_HIGH;
    end
    else
    begin
      nxt_state.irq_req = high_req | low_req;
      nxt_state.vector  = high_req ? `VECTOR_HIGH : `VECTOR_LOW;
    end

    // Pull-ups follow the disable bit and latch.
    nxt_state.pu_dis = nxt_state.edge_pri[`EDGE_PU_DIS_BIT];
    nxt_state.pu_en  = nxt_state.edge_pri[`EDGE_PU_DIS_BIT] ? 8'h00 : port_latch;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_ff           <= '0;
      state_ff.main_ctrl <= `RST_MAIN_CTRL;
      state_ff.edge_pri  <= `RST_EDGE_PRI_CTRL;
      state_ff.ext_ctrl  <= `RST_EXT_PIN_CTRL;
      state_ff.vector    <= `VECTOR_HIGH;
      state_ff.pu_dis    <= 1'b1;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign s_axi_awready       = state_ff.awready;
  assign s_axi_wready        = state_ff.wready;
  assign s_axi_bvalid        = state_ff.bvalid;
  assign s_axi_bresp         = state_ff.bresp;
  assign s_axi_arready       = state_ff.arready;
  assign s_axi_rvalid        = state_ff.rvalid;
  assign s_axi_rresp         = state_ff.rresp;
  assign s_axi_rdata         = state_ff.rdata;
  assign irq_req             = state_ff.irq_req;
  assign irq_vector          = state_ff.vector;
  assign port_pullup_disable = state_ff.pu_dis;
  assign pullup_enable       = state_ff.pu_en;

endmodule : irq_ctrl

// >>> rtl/irq_ctrl_defines.svh
// Purpose: Constants of the interrupt controller.
// Assumes: Byte addresses on a 32-bit AXI4-Lite bus, one aligned word per register.
// Notes:   Definitions only.
`ifndef IRQ_CTRL_DEFINES_SVH
`define IRQ_CTRL_DEFINES_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_MAIN_CTRL      8'h00
`define OFS_EDGE_PRI_CTRL  8'h04
`define OFS_EXT_PIN_CTRL   8'h08
`define OFS_RESET_STATUS   8'h0c
`define OFS_CTRL_STATUS    8'h10

// ****************************************************************
// Field positions
// ****************************************************************
`define MAIN_GLOBAL_BIT    7
`define MAIN_GROUP_BIT     6
`define MAIN_T0_EN_BIT     5
`define MAIN_P0_EN_BIT     4
`define MAIN_PC_EN_BIT     3
`define MAIN_T0_FLAG_BIT   2
`define MAIN_P0_FLAG_BIT   1
`define MAIN_PC_FLAG_BIT   0
`define EDGE_PU_DIS_BIT    7
`define EDGE_SEL_P0_BIT    6
`define EDGE_SEL_P1_BIT    5
`define EDGE_SEL_P2_BIT    4
`define EDGE_T0_PRI_BIT    2
`define EDGE_PC_PRI_BIT    0
`define EXT_P2_PRI_BIT     7
`define EXT_P1_PRI_BIT     6
`define EXT_P2_EN_BIT      4
`define EXT_P1_EN_BIT      3
`define EXT_P2_FLAG_BIT    1
`define EXT_P1_FLAG_BIT    0
`define RST_PRIO_MODE_BIT  7

// ****************************************************************
// Reset values, writable masks, vectors and bus answers
// ****************************************************************
`define RST_MAIN_CTRL      8'h00
`define RST_EDGE_PRI_CTRL  8'hf5
`define RST_EXT_PIN_CTRL   8'hc0
`define MASK_EDGE_PRI_CTRL 8'hf5
`define MASK_EXT_PIN_CTRL  8'hdb
`define VECTOR_HIGH        24'h000008
`define VECTOR_LOW         24'h000018
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// >>> rtl/irq_ctrl_pkg.sv
// Purpose: Types shared by the interrupt controller files.
// Assumes: Constants live in irq_ctrl_defines.svh.
// Notes:   Types only.
package irq_ctrl_pkg;

  // ****************************************************************
  // Register selection
  // ****************************************************************
  typedef enum logic [2:0] {
    REG_MAIN,
    REG_EDGE_PRI,
    REG_EXT_PIN,
    REG_RESET_STATUS,
    REG_CTRL_STATUS,
    REG_NONE
  } reg_id_t;

endpackage : irq_ctrl_pkg

// >>> rtl/pin_edge_detect.sv
// Purpose: Synchronises the three external interrupt pins and detects the selected edge.
// Assumes: Pins may change at any time relative to aclk.
// Notes:   Edge pulses are combinational; flags land one edge later.
`timescale 1ns/10ps
module pin_edge_detect (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [2:0] pin_in,
  input  wire logic [2:0] edge_rising_sel,
  output logic      [2:0] edge_pulse
);

  typedef struct packed {
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic [2:0] prev;
    logic [2:0] primed;
  } state_t;

  state_t state_ff;
  state_t nxt_state;

  always_comb
  begin
    nxt_state        = state_ff;
    nxt_state.sync_a = pin_in;
    nxt_state.sync_b = state_ff.sync_a;
    nxt_state.prev   = state_ff.sync_b;
    nxt_state.primed = {state_ff.primed[1:0], 1'b1};
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_ff <= '0;
    else
      state_ff <= nxt_state;
  end

  // ****************************************************************
  // Edge detection per pin
  // ****************************************************************
  // No edges until both stages hold real levels, so an idle-high pin gives no false event.
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_edge
      assign edge_pulse[gi] = state_ff.primed[2] & (edge_rising_sel[gi] ?
                              (state_ff.sync_b[gi] & ~state_ff.prev[gi]) :
                              (~state_ff.sync_b[gi] & state_ff.prev[gi]));
    end
  endgenerate

endmodule : pin_edge_detect

// >>> rtl/port_change_detect.sv
// Purpose: Mismatch detector for the upper four port pins.
// Assumes: Port pins synchronous to aclk; a port read is a one-cycle strobe.
// Notes:   The mismatch is up while the pins differ from the snapshot; a port read retakes the snapshot.
`timescale 1ns/10ps
module port_change_detect (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [3:0] upper_port_pins,
  input  wire logic       port_b_register_read,
  output logic            mismatch
);

  typedef struct packed {
    logic [3:0] snapshot;
    logic       primed;
    logic       mismatch;
  } state_t;

  state_t state_ff;
  state_t nxt_state;

  always_comb
  begin
    nxt_state        = state_ff;
    nxt_state.primed = 1'b1;
    if (!state_ff.primed || port_b_register_read)
      nxt_state.snapshot = upper_port_pins;
    nxt_state.mismatch = state_ff.primed && !port_b_register_read &&
                         (upper_port_pins != state_ff.snapshot);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_ff <= '0;
    else
      state_ff <= nxt_state;
  end

  assign mismatch = state_ff.mismatch;

endmodule : port_change_detect

// >>> dv/irq_ctrl_monitor.sv
// Purpose: Concurrent checks on the ports of the interrupt controller.
// Assumes: One clock domain; reset is synchronous and active low.
// Notes:   Bound into the controller.
`timescale 1ns/10ps
`include "irq_ctrl_defines.svh"
module irq_ctrl_monitor (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_awvalid,
  input  wire logic        s_axi_awready,
  input  wire logic        s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic        s_axi_rvalid,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic        irq_ack,
  input  wire logic        irq_req,
  input  wire logic [23:0] irq_vector,
  input  wire logic        port_pullup_disable,
  input  wire logic [7:0]  port_latch,
  input  wire logic [7:0]  pullup_enable
);
  // ****
  // Checks
  // ****
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_b_answer;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  a_vector_legal: assert property (irq_req |-> irq_vector == `VECTOR_HIGH || irq_vector == `VECTOR_LOW)
    else $error("vector is neither entry");
  a_ack_drops_req: assert property (irq_req && irq_ack |=> !irq_req)
    else $error("request stayed up after acceptance");
  a_pullup_off: assert property (port_pullup_disable && $past(port_pullup_disable) |-> pullup_enable == 8'h00)
    else $error("pull-ups on while disabled");
  a_pullup_latch: assert property (!port_pullup_disable && $past(!port_pullup_disable) && $stable(port_latch)
    |-> pullup_enable == port_latch)
    else $error("pull-ups do not follow the latch");
  a_write_answer: assert property (s_wr_taken |=> s_b_answer)
    else $error("write answer late or early");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > `OFS_CTRL_STATUS
    |=> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
endmodule : irq_ctrl_monitor
bind irq_ctrl irq_ctrl_monitor irq_ctrl_monitor_i (.*);

// >>> dv/core_model.sv
// Purpose: Behavioural processor core that takes interrupts and returns from them.
// Assumes: One instruction cycle is one clock.
// Notes:   Acks every request one clock after it rises; returns only on ret_cmd.
`timescale 1ns/10ps
module core_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        irq_req,
  input  wire logic [23:0] irq_vector,
  input  wire logic        ret_cmd,
  output logic             irq_ack,
  output logic             return_from_interrupt_instr,
  output logic [23:0]      pc,
  output int               depth
);
  // ****
  // Core
  // ****
  logic [23:0] stack_q [$];
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stack_q.delete();
      {irq_ack, return_from_interrupt_instr} <= 2'b00;
      pc <= 24'h000100;
    end
    else
    begin
      irq_ack <= irq_req && !irq_ack;
      return_from_interrupt_instr <= ret_cmd;
      if (irq_req && irq_ack)
      begin
        stack_q.push_back(pc);
        pc <= irq_vector;
      end
      else if (return_from_interrupt_instr && stack_q.size() > 0)
        pc <= stack_q.pop_back();
    end
    depth <= stack_q.size();
  end
endmodule : core_model

// >>> dv/tb_top.sv
// Purpose: Self-checking bench for the interrupt controller with a core model.
// Assumes: 10 MHz clock.
// Notes:   Each scenario starts from its own reset.
`timescale 1ns/10ps
`include "irq_ctrl_defines.svh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin failures++; $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module tb_top;
  // ****
  // Bench
  // ****
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_req, irq_ack;
  logic        timer_zero_overflow_evt, port_b_register_read, periph_req_high, periph_req_low, ret_cmd;
  logic        return_from_interrupt_instr, port_pullup_disable;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, port_latch, pullup_enable;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
  logic [3:0]  s_axi_wstrb, upper_port_pins;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rd_resp, wr_resp;
  logic [2:0]  ext_pin;
  logic [23:0] irq_vector, pc;
  int          depth, failures, n_tests, cyc, lat;
  irq_ctrl irq_ctrl_i (.*);
  core_model core_model_i (.*);
  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      failures++;
      test_done();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick
  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    tick(3);
    aresetn <= 1'b1;
    tick(2);
  endtask : do_reset
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    fork
      begin
        do @(posedge aclk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (s_axi_wready !== 1'b1);
        s_axi_wvalid <= 1'b0;
      end
    join
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    wr_resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    {rd_data, rd_resp} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic pulse(input int k);
    @(posedge aclk);
    if (k == 0) timer_zero_overflow_evt <= 1'b1;
    else if (k == 1) port_b_register_read <= 1'b1;
    else ret_cmd <= 1'b1;
    @(posedge aclk);
    {timer_zero_overflow_evt, port_b_register_read, ret_cmd} <= 3'b000;
  endtask : pulse
  task automatic take_irq();
    lat = 0;
    while (irq_req !== 1'b1 && lat < 20)
    begin
      @(posedge aclk);
      lat++;
    end
    tick(3);
  endtask : take_irq
  task automatic t_regs();
    logic [7:0] ofs [4] = '{`OFS_MAIN_CTRL, `OFS_EDGE_PRI_CTRL, `OFS_EXT_PIN_CTRL, `OFS_RESET_STATUS};
    logic [7:0] rv [4] = '{`RST_MAIN_CTRL, `RST_EDGE_PRI_CTRL, `RST_EXT_PIN_CTRL, 8'h00};
    logic [7:0] wm [4] = '{8'h00, `MASK_EDGE_PRI_CTRL, `MASK_EXT_PIN_CTRL, 8'h80};
    do_reset();
    for (int i = 0; i < 4; i++)
    begin
      rd(ofs[i]);
      `CHK(rd_data, {24'h0, rv[i]})
    end
    for (int i = 1; i < 4; i++)
    begin
      wr(ofs[i], 8'hff);
      rd(ofs[i]);
      `CHK(rd_data, {24'h0, wm[i]})
    end
    wr(8'h14, 8'hff);
    `CHK(wr_resp, `RESP_SLVERR)
    rd(8'h14);
    `CHK(rd_resp, `RESP_SLVERR)
    $display("t_regs done");
  endtask : t_regs
  task automatic t_compat();
    do_reset();
    wr(`OFS_EDGE_PRI_CTRL, 8'hf1);
    wr(`OFS_MAIN_CTRL, 8'h20);
    pulse(0);
    tick(4);
    `CHK(irq_req, 1'b0)
    rd(`OFS_MAIN_CTRL);
    `CHK(rd_data[7:0], 8'h24)
    wr(`OFS_MAIN_CTRL, 8'ha4);
    take_irq();
    `CHK(pc, `VECTOR_HIGH)
    rd(`OFS_MAIN_CTRL);
    `CHK(rd_data[7:0], 8'h24)
    wr(`OFS_MAIN_CTRL, 8'h20);
    pulse(2);
    rd(`OFS_MAIN_CTRL);
    `CHK(rd_data[7:0], 8'ha0)
    periph_req_low <= 1'b1;
    tick(5);
    `CHK(irq_req, 1'b0)
    wr(`OFS_MAIN_CTRL, 8'he0);
    take_irq();
    `CHK(pc, `VECTOR_HIGH)
    periph_req_low <= 1'b0;
    $display("t_compat done");
  endtask : t_compat
  task automatic t_prio();
    do_reset();
    wr(`OFS_RESET_STATUS, 8'h80);
    wr(`OFS_EDGE_PRI_CTRL, 8'hb5);
    wr(`OFS_MAIN_CTRL, 8'hd0);
    ext_pin <= 3'b110;
    take_irq();
    `CHK(lat >= 3 && lat <= 4, 1'b1)
    `CHK(pc, `VECTOR_HIGH)
    wr(`OFS_MAIN_CTRL, 8'h50);
    periph_req_low <= 1'b1;
    tick(5);
    `CHK(irq_req, 1'b0)
    pulse(2);
    take_irq();
    `CHK(pc, `VECTOR_LOW)
    rd(`OFS_MAIN_CTRL);
    `CHK(rd_data[7:0], 8'h90)
    periph_req_low <= 1'b0;
    periph_req_high <= 1'b1;
    take_irq();
    `CHK(pc, `VECTOR_HIGH)
    `CHK(depth, 2)
    periph_req_high <= 1'b0;
    $display("t_prio done");
  endtask : t_prio
  task automatic t_flags();
    ext_pin <= 3'b111;
    do_reset();
    wr(`OFS_EDGE_PRI_CTRL, 8'h05);
    `CHK(pullup_enable, port_latch)
    ext_pin <= 3'b000;
    upper_port_pins <= 4'h5;
    pulse(0);
    tick(6);
    rd(`OFS_MAIN_CTRL);
    `CHK(rd_data[7:0], 8'h07)
    rd(`OFS_EXT_PIN_CTRL);
    `CHK(rd_data[7:0], 8'hc3)
    wr(`OFS_EXT_PIN_CTRL, 8'hc0);
    ext_pin <= 3'b111;
    tick(6);
    rd(`OFS_EXT_PIN_CTRL);
    `CHK(rd_data[7:0], 8'hc0)
    wr(`OFS_MAIN_CTRL, 8'h00);
    rd(`OFS_MAIN_CTRL);
    `CHK(rd_data[7:0], 8'h01)
    pulse(1);
    wr(`OFS_MAIN_CTRL, 8'h00);
    rd(`OFS_MAIN_CTRL);
    `CHK(rd_data[7:0], 8'h00)
    $display("t_flags done");
  endtask : t_flags
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done
  initial
  begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, timer_zero_overflow_evt} = '0;
    {port_b_register_read, periph_req_high, periph_req_low, ret_cmd, upper_port_pins} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {8'h00, 8'h00, 32'h0, 4'h1};
    {ext_pin, port_latch} = {3'b111, 8'ha5};
    t_regs();
    t_compat();
    t_prio();
    t_flags();
    test_done();
  end
endmodule : tb_top
